// ---- core/mitd_decode.v ----
`include "mitd_defines.vh"
`default_nettype none
// Contract
// - and/or direct-immediate: three bytes, 24 periods
// - rotate left through carry: 1 byte, 12
// - nibble swap accumulator: 1 byte, 12
// - load pointer pair immediate: 3 bytes, 24
// - code read at acc+pointer: 1 byte, 24
// - external data moves: 1 byte, 24
// - push and pop direct: 2 bytes, 24
// - low digit exchange: 1 byte, 12
// - bit test jump clears set bit: 3,24
// - page targets stay in 2k page
// - long targets reach full 64k space
// - relative offsets signed, from next instruction
// - direct below 128 RAM, else registers
// - indirect via pointer reaches RAM 0-255
// - writes to 208 or 209-215 touch flags
// - compare immediate indirect branch: 3,24
// - decrement direct branch nonzero: 3,24
// - direct to direct move: 3,24
// - indirect jump to acc plus pointer: 1,24
module mitd_decode (
    // clock and reset
    input wire i_clock,
    input wire i_srst,
    // instruction bytes and start strobe
    input wire i_start,
    input wire [7:0] i_opcode,
    input wire [7:0] i_byte1,
    input wire [7:0] i_byte2,
    input wire [15:0] i_pc,
    // operand values
    input wire [7:0] i_acc,
    input wire [15:0] i_data_pointer_pair,
    input wire i_carry,
    input wire i_bit_value,
    input wire [7:0] i_dir_data,
    input wire [7:0] i_ind_data,
    input wire [7:0] i_pointer_register_zero,
    input wire [7:0] i_pointer_register_one,
    // timing results
    output reg o_busy,
    output reg o_done,
    output reg [1:0] o_length,
    output reg [5:0] o_periods,
    // branch results
    output reg o_branch,
    output reg [15:0] o_target,
    // accumulator and memory results
    output reg [7:0] o_acc,
    output reg o_carry,
    output reg o_ind_we,
    output reg [7:0] o_ind_addr,
    output reg [7:0] o_ind_wdata,
    output reg o_dir_we,
    output reg [7:0] o_dir_addr,
    output reg o_dir_is_sfr,
    output reg [7:0] o_dir_wdata,
    output reg o_bit_clear,
    output reg o_psw_touch,
    output reg o_ext_rd,
    output reg o_ext_wr,
    output reg o_code_rd,
    output reg [15:0] o_mem_addr
);

    // ==========================================================
    // latched instruction
    reg [7:0] op_q, b1_q, b2_q, acc_q, dird_q, indd_q, ptr_q;
    reg [15:0] pc_q, dp_q;
    reg cy_q, bitv_q;
    // sequencer state
    reg [3:0] osc_q;
    reg [2:0] mc_q;
    // decode of the incoming opcode (length and cost)
    reg [1:0] len_d;
    reg [5:0] per_d;
    // results from latched operands
    reg [15:0] next_pc, rel_tgt, tgt_d, addr_d;
    reg br_d, dwe_d, iwe_d, bclr_d, erd_d, ewr_d, crd_d;
    reg [7:0] acc_d, daddr_d, dwd_d, iwd_d;
    reg cy_d;
    wire [2:0] mcyc_d;

    // ==========================================================
    // length and oscillator-period cost of the opcode at start
    always @* begin
        len_d = 2'd1;
        per_d = `MITD_COST_SHORT;
        if (i_opcode[4:0] == `MITD_OP_PAGE_JUMP || i_opcode[4:0] == `MITD_OP_PAGE_CALL) begin
            len_d = 2'd2;
            per_d = `MITD_COST_LONG;
        end else begin
            case (i_opcode)
                `MITD_OP_AND_DIR_IMM, `MITD_OP_OR_DIR_IMM,
                `MITD_OP_LOAD_PTR_PAIR,
                `MITD_OP_TEST_CLEAR_JUMP, `MITD_OP_JUMP_BIT, `MITD_OP_JUMP_NO_BIT,
                `MITD_OP_DEC_BRANCH_DIR,
                `MITD_OP_MOVE_DIR_DIR,
                `MITD_OP_LONG_JUMP, `MITD_OP_LONG_CALL: begin
                    len_d = 2'd3;
                    per_d = `MITD_COST_LONG;
                end
                `MITD_OP_PUSH, `MITD_OP_POP,
                `MITD_OP_SHORT_REL_JUMP, `MITD_OP_JUMP_CARRY, `MITD_OP_JUMP_NO_CARRY,
                `MITD_OP_JUMP_ZERO, `MITD_OP_JUMP_NONZERO: begin
                    len_d = 2'd2;
                    per_d = `MITD_COST_LONG;
                end
                `MITD_OP_CODE_READ,
                `MITD_OP_EXT_READ, `MITD_OP_EXT_WRITE,
                `MITD_OP_INDIRECT_JUMP: begin
                    len_d = 2'd1;
                    per_d = `MITD_COST_LONG;
                end
                default: begin
                    if (i_opcode[7:1] == `MITD_OP_CMP_BRANCH_IND) begin
                        len_d = 2'd3;
                        per_d = `MITD_COST_LONG;
                    end
                end
            endcase
        end
    end

    assign mcyc_d = (per_d == `MITD_COST_LONG) ? 3'd2 : 3'd1;

    // ==========================================================
    // execution results from the latched instruction
    always @* begin
        next_pc = pc_q + {14'h0000, o_length};
        rel_tgt = next_pc + {{8{b2_q[7]}}, b2_q};
        tgt_d = next_pc;
        addr_d = 16'h0000;
        br_d = 1'b0;
        dwe_d = 1'b0;
        iwe_d = 1'b0;
        bclr_d = 1'b0;
        erd_d = 1'b0;
        ewr_d = 1'b0;
        crd_d = 1'b0;
        acc_d = acc_q;
        cy_d = cy_q;
        daddr_d = b1_q;
        dwd_d = dird_q;
        iwd_d = indd_q;
        if (op_q[4:0] == `MITD_OP_PAGE_JUMP || op_q[4:0] == `MITD_OP_PAGE_CALL) begin
            // keep page bits of next pc
            br_d = 1'b1;
            tgt_d = {next_pc[15:11], op_q[7:5], b1_q};
        end else begin
            case (op_q)
                `MITD_OP_AND_DIR_IMM: begin
                    dwe_d = 1'b1;
                    dwd_d = dird_q & b2_q;
                end
                `MITD_OP_OR_DIR_IMM: begin
                    dwe_d = 1'b1;
                    dwd_d = dird_q | b2_q;
                end
                `MITD_OP_ROT_LEFT_CARRY: begin
                    acc_d = {acc_q[6:0], cy_q};
                    cy_d = acc_q[7];
                end
                `MITD_OP_NIBBLE_SWAP: acc_d = {acc_q[3:0], acc_q[7:4]};
                `MITD_OP_LOAD_PTR_PAIR: addr_d = {b1_q, b2_q};
                `MITD_OP_CODE_READ: begin
                    crd_d = 1'b1;
                    addr_d = dp_q + {8'h00, acc_q};
                end
                `MITD_OP_EXT_READ: begin
                    erd_d = 1'b1;
                    addr_d = dp_q;
                end
                `MITD_OP_EXT_WRITE: begin
                    ewr_d = 1'b1;
                    addr_d = dp_q;
                end
                `MITD_OP_POP: dwe_d = 1'b1;
                `MITD_OP_TEST_CLEAR_JUMP: begin
                    br_d = bitv_q;
                    bclr_d = bitv_q;
                    tgt_d = rel_tgt;
                end
                `MITD_OP_JUMP_BIT: begin
                    br_d = bitv_q;
                    tgt_d = rel_tgt;
                end
                `MITD_OP_JUMP_NO_BIT: begin
                    br_d = ~bitv_q;
                    tgt_d = rel_tgt;
                end
                `MITD_OP_LONG_JUMP, `MITD_OP_LONG_CALL: begin
                    br_d = 1'b1;
                    tgt_d = {b1_q, b2_q};
                end
                // two-byte relative forms take their offset from byte one
                `MITD_OP_SHORT_REL_JUMP: begin
                    br_d = 1'b1;
                    tgt_d = next_pc + {{8{b1_q[7]}}, b1_q};
                end
                `MITD_OP_JUMP_CARRY, `MITD_OP_JUMP_NO_CARRY: begin
                    br_d = cy_q ^ op_q[4];
                    tgt_d = next_pc + {{8{b1_q[7]}}, b1_q};
                end
                `MITD_OP_JUMP_ZERO, `MITD_OP_JUMP_NONZERO: begin
                    br_d = (acc_q == 8'h00) ^ op_q[4];
                    tgt_d = next_pc + {{8{b1_q[7]}}, b1_q};
                end
                `MITD_OP_INDIRECT_JUMP: begin
                    br_d = 1'b1;
                    tgt_d = dp_q + {8'h00, acc_q};
                end
                `MITD_OP_DEC_BRANCH_DIR: begin
                    dwe_d = 1'b1;
                    dwd_d = dird_q - 8'h01;
                    br_d = (dird_q != 8'h01);
                    tgt_d = rel_tgt;
                end
                // source byte one, destination byte two
                `MITD_OP_MOVE_DIR_DIR: begin
                    dwe_d = 1'b1;
                    daddr_d = b2_q;
                end
                default: begin
                    if (op_q[7:1] == `MITD_OP_LOW_DIGIT_XCH) begin
                        acc_d = {acc_q[7:4], indd_q[3:0]};
                        iwd_d = {indd_q[7:4], acc_q[3:0]};
                        iwe_d = 1'b1;
                    end
                    if (op_q[7:1] == `MITD_OP_CMP_BRANCH_IND) begin
                        br_d = (indd_q != b1_q);
                        cy_d = (indd_q < b1_q);
                        tgt_d = rel_tgt;
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // latch operands and sequence machine cycles
    always @(posedge i_clock) begin
        if (i_srst) begin
            o_busy <= 1'b0;
            o_length <= 2'd0;
            o_periods <= 6'h00;
            osc_q <= 4'h0;
            mc_q <= 3'd0;
            op_q <= 8'h00;
            b1_q <= 8'h00;
            b2_q <= 8'h00;
            pc_q <= 16'h0000;
            acc_q <= 8'h00;
            dp_q <= 16'h0000;
            cy_q <= 1'b0;
            bitv_q <= 1'b0;
            dird_q <= 8'h00;
            indd_q <= 8'h00;
            ptr_q <= 8'h00;
        end else if (!o_busy) begin
            // a start while busy is ignored
            if (i_start) begin
                o_busy <= 1'b1;
                o_length <= len_d;
                o_periods <= per_d;
                osc_q <= 4'h0;
                mc_q <= mcyc_d;
                op_q <= i_opcode;
                b1_q <= i_byte1;
                b2_q <= i_byte2;
                pc_q <= i_pc;
                acc_q <= i_acc;
                dp_q <= i_data_pointer_pair;
                cy_q <= i_carry;
                bitv_q <= i_bit_value;
                dird_q <= i_dir_data;
                indd_q <= i_ind_data;
                // pointer selected by opcode bit 0
                ptr_q <= i_opcode[0] ? i_pointer_register_one : i_pointer_register_zero;
            end
        end else if (osc_q == `MITD_PERIODS_PER_MCYCLE) begin
            osc_q <= 4'h0;
            mc_q <= mc_q - 3'd1;
            if (mc_q == 3'd1) begin
                o_busy <= 1'b0;
            end
        end else begin
            osc_q <= osc_q + 4'h1;
        end
    end

    // ==========================================================
    // register results at the last period of the instruction
    always @(posedge i_clock) begin
        if (i_srst) begin
            o_done <= 1'b0;
            o_branch <= 1'b0;
            o_target <= 16'h0000;
            o_acc <= 8'h00;
            o_carry <= 1'b0;
            o_ind_we <= 1'b0;
            o_ind_addr <= 8'h00;
            o_ind_wdata <= 8'h00;
            o_dir_we <= 1'b0;
            o_dir_addr <= 8'h00;
            o_dir_is_sfr <= 1'b0;
            o_dir_wdata <= 8'h00;
            o_bit_clear <= 1'b0;
            o_psw_touch <= 1'b0;
            o_ext_rd <= 1'b0;
            o_ext_wr <= 1'b0;
            o_code_rd <= 1'b0;
            o_mem_addr <= 16'h0000;
        end else if (o_busy && osc_q == `MITD_PERIODS_PER_MCYCLE && mc_q == 3'd1) begin
            o_done <= 1'b1;
            o_branch <= br_d;
            o_target <= tgt_d;
            o_acc <= acc_d;
            o_carry <= cy_d;
            o_ind_we <= iwe_d;
            o_ind_addr <= ptr_q;
            o_ind_wdata <= iwd_d;
            o_dir_we <= dwe_d;
            o_dir_addr <= daddr_d;
            o_dir_is_sfr <= daddr_d[7];
            o_dir_wdata <= dwd_d;
            o_bit_clear <= bclr_d;
            // flag side effect on status word
            o_psw_touch <= (dwe_d && daddr_d == `MITD_PSW_ADDR) ||
                (bclr_d && b1_q >= `MITD_PSW_BIT_LO && b1_q <= `MITD_PSW_BIT_HI);
            o_ext_rd <= erd_d;
            o_ext_wr <= ewr_d;
            o_code_rd <= crd_d;
            o_mem_addr <= addr_d;
        end else begin
            // strobes last one cycle, data holds
            o_done <= 1'b0;
            o_ind_we <= 1'b0;
            o_dir_we <= 1'b0;
            o_bit_clear <= 1'b0;
            o_psw_touch <= 1'b0;
            o_ext_rd <= 1'b0;
            o_ext_wr <= 1'b0;
            o_code_rd <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// ---- pkg/mitd_defines.vh ----
`ifndef MITD_DEFINES_VH
`define MITD_DEFINES_VH
// ==========================================================
// timing: one clock edge is one oscillator period
`define MITD_PERIODS_PER_MCYCLE 4'd11
`define MITD_MC_PERIODS 12
`define MITD_COST_SHORT 6'h0c
`define MITD_COST_LONG 6'h18
// ==========================================================
// address spaces
`define MITD_SFR_BASE 8'h80
`define MITD_PSW_ADDR 8'hd0
`define MITD_PSW_BIT_LO 8'hd1
`define MITD_PSW_BIT_HI 8'hd7
// ==========================================================
// opcodes
`define MITD_OP_AND_DIR_IMM 8'h53
`define MITD_OP_OR_DIR_IMM 8'h43
`define MITD_OP_ROT_LEFT_CARRY 8'h33
`define MITD_OP_NIBBLE_SWAP 8'hc4
`define MITD_OP_LOAD_PTR_PAIR 8'h90
`define MITD_OP_CODE_READ 8'h93
`define MITD_OP_EXT_READ 8'he0
`define MITD_OP_EXT_WRITE 8'hf0
`define MITD_OP_PUSH 8'hc0
`define MITD_OP_POP 8'hd0
`define MITD_OP_LOW_DIGIT_XCH 7'h6b
`define MITD_OP_TEST_CLEAR_JUMP 8'h10
`define MITD_OP_PAGE_JUMP 5'h01
`define MITD_OP_PAGE_CALL 5'h11
`define MITD_OP_LONG_JUMP 8'h02
`define MITD_OP_LONG_CALL 8'h12
`define MITD_OP_SHORT_REL_JUMP 8'h80
`define MITD_OP_INDIRECT_JUMP 8'h73
`define MITD_OP_CMP_BRANCH_IND 7'h5b
`define MITD_OP_DEC_BRANCH_DIR 8'hd5
`define MITD_OP_MOVE_DIR_DIR 8'h85
`define MITD_OP_JUMP_CARRY 8'h40
`define MITD_OP_JUMP_NO_CARRY 8'h50
`define MITD_OP_JUMP_ZERO 8'h60
`define MITD_OP_JUMP_NONZERO 8'h70
`define MITD_OP_JUMP_BIT 8'h20
`define MITD_OP_JUMP_NO_BIT 8'h30
`endif

// ---- sim/mitd_decode_sva.sv ----
`default_nettype none
// ==========================================
// timing and strobe checker for the decode core
module mitd_decode_sva (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_srst,
    // request
    input wire logic i_start,
    // timing results
    input wire logic o_busy,
    input wire logic o_done,
    input wire logic [1:0] o_length,
    input wire logic [5:0] o_periods,
    // strobes and addresses
    input wire logic o_dir_we,
    input wire logic [7:0] o_dir_addr,
    input wire logic o_dir_is_sfr,
    input wire logic o_psw_touch,
    input wire logic o_ind_we,
    input wire logic o_bit_clear,
    input wire logic o_ext_rd,
    input wire logic o_ext_wr,
    input wire logic o_code_rd
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_srst);
    // ==========================================
    // cycle counts of one and two machine cycles
    chk_short_cost: assert property (
        (i_start && !o_busy) ##1 (o_periods == 6'h0c) |-> ##12 o_done)
        else $error("short op not done after 12 periods");
    chk_long_cost: assert property (
        (i_start && !o_busy) ##1 (o_periods == 6'h18) |-> (!o_done) [*8] ##17 o_done)
        else $error("long op not done after 24 periods");
    chk_done_pulse: assert property (o_done |=> !o_done)
        else $error("done longer than one cycle");
    chk_busy_ends: assert property ($fell(o_busy) |-> o_done)
        else $error("busy dropped without done");
    chk_hold_cost: assert property (o_busy |=> $stable(o_length) && $stable(o_periods))
        else $error("length or cost changed while busy");
    chk_len_cost: assert property (
        o_done |-> o_length != 2'h0 && (o_periods == 6'h0c || o_periods == 6'h18)
        && (o_length == 2'h1 || o_periods == 6'h18))
        else $error("length and cost do not agree");
    // ==========================================
    // address spaces and side effects
    chk_sfr_split: assert property (o_dir_we |-> o_dir_is_sfr == o_dir_addr[7])
        else $error("direct space flag wrong");
    chk_psw_touch: assert property ((o_dir_we && o_dir_addr == 8'hd0) |-> o_psw_touch)
        else $error("status word write not flagged");
    chk_strobe_done: assert property (
        (o_dir_we || o_ind_we || o_bit_clear || o_ext_rd || o_ext_wr || o_code_rd)
        |-> o_done && !o_busy)
        else $error("strobe outside the done cycle");
endmodule
bind mitd_decode mitd_decode_sva mitd_decode_sva_i (.*);
`default_nettype wire

// ---- sim/mitd_mem_model.sv ----
`default_nettype none
// ==========================================
// internal ram, register space and bit space
module mitd_mem_model (
    // clock
    input wire logic i_clock,
    // operand selection
    input wire logic [7:0] i_opcode,
    input wire logic [7:0] i_byte1,
    input wire logic [7:0] i_ptr0,
    input wire logic [7:0] i_ptr1,
    // writes from the core
    input wire logic i_dir_we,
    input wire logic [7:0] i_dir_addr,
    input wire logic [7:0] i_dir_wdata,
    input wire logic i_ind_we,
    input wire logic [7:0] i_ind_addr,
    input wire logic [7:0] i_ind_wdata,
    input wire logic i_bit_clear,
    // operand values
    output logic [7:0] o_dir_data,
    output logic [7:0] o_ind_data,
    output logic o_bit_value
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] ram [0:255]; // internal ram
    logic [7:0] special_function_register [128:255]; // register space
    logic [7:0] bit_q; // bit address of the running op
    // low half is ram, high half registers
    assign o_dir_data = i_byte1[7] ? special_function_register[i_byte1] : ram[i_byte1];
    assign o_ind_data = ram[i_opcode[0] ? i_ptr1 : i_ptr0];
    // low bits live in ram 32..47, high bits in registers
    assign o_bit_value = i_byte1[7] ? special_function_register[{i_byte1[7:3], 3'h0}][i_byte1[2:0]]
        : ram[{4'h2, i_byte1[6:3]}][i_byte1[2:0]];
    // varied start contents
    initial begin
        for (int k = 0; k < 256; k++) begin
            ram[k] = 8'(k * 7 + 3);
            if (k > 127) special_function_register[k] = 8'(k * 5 + 1);
        end
    end
    // writes land at the edge after done
    always @(posedge i_clock) begin
        bit_q <= i_byte1;
        if (i_dir_we && i_dir_addr[7]) special_function_register[i_dir_addr] <= i_dir_wdata;
        else if (i_dir_we) ram[i_dir_addr] <= i_dir_wdata;
        if (i_ind_we) ram[i_ind_addr] <= i_ind_wdata;
        // cleared bit lands in its byte
        if (i_bit_clear && bit_q[7]) special_function_register[{bit_q[7:3], 3'h0}][bit_q[2:0]] <= 1'b0;
        else if (i_bit_clear) ram[{4'h2, bit_q[6:3]}][bit_q[2:0]] <= 1'b0;
    end
endmodule
`default_nettype wire

// ---- sim/testbench.sv ----
`default_nettype none
// ==========================================
// self-checking bench for the decode core
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    // stimulus, set at the falling edge
    logic i_clock = '0;
    logic i_srst = '1;
    logic i_start = '0;
    logic i_carry = '0;
    logic [7:0] i_opcode = '0, i_byte1 = '0, i_byte2 = '0, i_acc = '0;
    logic [7:0] i_pointer_register_zero = '0, i_pointer_register_one = '0;
    logic [15:0] i_pc = '0, i_data_pointer_pair = '0;
    // operand values from the memory model
    wire logic i_bit_value;
    wire logic [7:0] i_dir_data, i_ind_data;
    // core results
    logic o_busy, o_done, o_branch, o_carry, o_ind_we, o_dir_we, o_dir_is_sfr;
    logic o_bit_clear, o_psw_touch, o_ext_rd, o_ext_wr, o_code_rd;
    logic [1:0] o_length;
    logic [5:0] o_periods;
    logic [7:0] o_acc, o_ind_addr, o_ind_wdata, o_dir_addr, o_dir_wdata;
    logic [15:0] o_target, o_mem_addr;
    // bookkeeping
    int num_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [7:0] rnd = 8'h53; // random state, starts at 83
    logic [7:0] ops [30] = '{8'h53, 8'h43, 8'h33, 8'hc4, 8'h90, 8'h93, 8'he0, 8'hf0,
        8'hc0, 8'hd0, 8'hd6, 8'hd7, 8'h10, 8'h01, 8'h11, 8'h02, 8'h12, 8'h80, 8'h73,
        8'hb6, 8'hb7, 8'hd5, 8'h85, 8'h40, 8'h50, 8'h60, 8'h70, 8'h20, 8'h30, 8'h00};
    mitd_decode mitd_decode_i (.*);
    mitd_mem_model mitd_mem_model_i (.i_clock(i_clock), .i_opcode(i_opcode),
        .i_byte1(i_byte1), .i_ptr0(i_pointer_register_zero),
        .i_ptr1(i_pointer_register_one), .i_dir_we(o_dir_we), .i_dir_addr(o_dir_addr),
        .i_dir_wdata(o_dir_wdata), .i_ind_we(o_ind_we), .i_ind_addr(o_ind_addr),
        .i_ind_wdata(o_ind_wdata), .i_bit_clear(o_bit_clear), .o_dir_data(i_dir_data),
        .o_ind_data(i_ind_data), .o_bit_value(i_bit_value));
    // 50 ns clock
    initial forever #25 i_clock = ~i_clock;
    // next random byte
    function automatic logic [7:0] rb();
        rnd = {rnd[6:0], rnd[7] ^ rnd[5] ^ rnd[4] ^ rnd[3]};
        return rnd;
    endfunction
    // sign extend a relative offset
    function automatic logic [15:0] sx(input logic [7:0] b);
        return {{8{b[7]}}, b};
    endfunction
    // compare and count
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL %0t op %h got %h expected %h", $time, i_opcode, got, exp);
        end
    endtask
    // verdict and end of run
    task automatic finish_test();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // one instruction against the reference model; hold keeps start high for that many cycles while busy
    task automatic run(input logic [7:0] op, input int hold, input int b1);
        int n, len, per;
        logic br, rel, bv;
        logic [7:0] dir, ind;
        logic [15:0] nxt, tgt;
        i_opcode = op;
        i_byte1 = (b1 < 0) ? rb() : b1[7:0];
        i_byte2 = rb();
        i_pc = {rb(), rb()};
        i_acc = rb();
        i_data_pointer_pair = {rb(), rb()};
        i_carry = ^rb();
        i_pointer_register_zero = rb();
        i_pointer_register_one = rb();
        i_start = '1;
        #1;
        dir = i_dir_data;
        ind = i_ind_data;
        bv = i_bit_value;
        @(negedge i_clock);
        check(o_busy, 1);
        if (hold > 0) i_opcode = 8'h00;
        n = 0;
        while (o_done !== 1'b1 && n < 40) begin
            if (n >= hold) i_start = '0;
            @(negedge i_clock);
            n++;
        end
        // length and cost per opcode
        casez (op)
            8'h53, 8'h43, 8'h90, 8'h10, 8'h02, 8'h12, 8'hb6, 8'hb7, 8'hd5, 8'h85, 8'h20,
            8'h30: begin len = 3; per = 24; end
            8'hc0, 8'hd0, 8'h80, 8'h40, 8'h50, 8'h60, 8'h70, 8'b????0001: begin
                len = 2; per = 24; end
            8'h93, 8'he0, 8'hf0, 8'h73: begin len = 1; per = 24; end
            default: begin len = 1; per = 12; end
        endcase
        check(n, per);
        check({o_length, o_periods}, {len[1:0], per[5:0]});
        // branch decision and target
        nxt = i_pc + len[15:0];
        tgt = nxt;
        br = 0;
        rel = 0;
        casez (op)
            8'h02, 8'h12: begin br = 1; tgt = {i_byte1, i_byte2}; end
            8'b????0001: begin br = 1; tgt = {nxt[15:11], op[7:5], i_byte1}; end
            8'h73: begin br = 1; tgt = i_acc + i_data_pointer_pair; end
            8'h80: rel = 1;
            8'h40: rel = i_carry;
            8'h50: rel = !i_carry;
            8'h60: rel = i_acc == 8'h00;
            8'h70: rel = i_acc != 8'h00;
            8'h20, 8'h10: rel = bv;
            8'h30: rel = !bv;
            8'hb6, 8'hb7: rel = ind != i_byte1;
            8'hd5: rel = dir != 8'h01;
            default: ;
        endcase
        // relative forms show their target whether taken or not
        if (op inside {8'h80, 8'h40, 8'h50, 8'h60, 8'h70, 8'h20, 8'h30, 8'h10, 8'hb6, 8'hb7,
            8'hd5}) tgt = nxt + sx(len == 2 ? i_byte1 : i_byte2);
        if (rel) br = 1;
        check({o_branch, o_target}, {br, tgt});
        // data results and strobes
        case (op)
            8'h33: check({o_acc, o_carry}, {i_acc[6:0], i_carry, i_acc[7]});
            8'hc4: check(o_acc, {i_acc[3:0], i_acc[7:4]});
            8'h53: check({o_dir_we, o_dir_addr, o_dir_wdata}, {1'b1, i_byte1, dir & i_byte2});
            8'h43: check({o_dir_we, o_dir_addr, o_dir_wdata}, {1'b1, i_byte1, dir | i_byte2});
            8'h90: check(o_mem_addr, {i_byte1, i_byte2});
            8'h93: check({o_code_rd, o_mem_addr}, {1'b1, i_acc + i_data_pointer_pair});
            8'he0: check({o_ext_rd, o_mem_addr}, {1'b1, i_data_pointer_pair});
            8'hf0: check({o_ext_wr, o_mem_addr}, {1'b1, i_data_pointer_pair});
            8'hd0: check({o_dir_we, o_dir_addr, o_dir_wdata, o_psw_touch},
                {1'b1, i_byte1, dir, i_byte1 == 8'hd0});
            8'hd6, 8'hd7: check({o_acc, o_ind_we, o_ind_addr, o_ind_wdata}, {i_acc[7:4],
                ind[3:0], 1'b1, op[0] ? i_pointer_register_one : i_pointer_register_zero,
                ind[7:4], i_acc[3:0]});
            8'h10: check({o_bit_clear, o_psw_touch},
                {bv, bv && i_byte1 >= 8'hd1 && i_byte1 <= 8'hd7});
            8'hb6, 8'hb7: check(o_carry, ind < i_byte1);
            8'hd5: check({o_dir_we, o_dir_wdata}, {1'b1, dir - 8'h01});
            8'h85: check({o_dir_we, o_dir_addr, o_dir_wdata}, {1'b1, i_byte2, dir});
            default: ;
        endcase
    endtask
    // hang guard
    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            finish_test();
        end
    end
    // main sequence
    initial begin
        repeat (8) @(negedge i_clock);
        i_srst = '0;
        foreach (ops[k]) run(ops[k], 0, -1);
        repeat (300) run(rb(), 0, -1);
        run(8'hd0, 0, 8'hd0);
        run(8'hc4, 5, -1);
        // reset in the middle of an op
        i_opcode = 8'h85;
        i_start = '1;
        @(negedge i_clock);
        i_start = '0;
        repeat (3) @(negedge i_clock);
        i_srst = '1;
        repeat (2) @(negedge i_clock);
        check({o_busy, o_done, o_length, o_periods, o_target}, 0);
        i_srst = '0;
        run(8'h12, 0, -1);
        finish_test();
    end
endmodule
`default_nettype wire
